//--- hw/arcs_defs.svh
// Register indices, reset values and timing counts of the analog reference curve scaler.
`ifndef ARCS_DEFS_SVH
`define ARCS_DEFS_SVH

// Register indices; the byte address is four times the index.
`define ARCS_IDX_MAX_FREQ      12'h100
`define ARCS_IDX_FIRST_BIAS    12'h303
`define ARCS_IDX_BIAS_MODE     12'h307
`define ARCS_IDX_REVERSE       12'h30a
`define ARCS_IDX_FIRST_GAIN    12'h30b
`define ARCS_IDX_TYPE_SELECT   12'h31c
`define ARCS_IDX_CURVE_SELECT  12'h332
`define ARCS_IDX_POS_FIRST     12'h33f
`define ARCS_IDX_NEG_FIRST     12'h345
`define ARCS_IDX_NEG_LAST      12'h34a
`define ARCS_IDX_NEG_VH        12'h345
`define ARCS_IDX_NEG_PH        12'h346
`define ARCS_IDX_NEG_VM        12'h347
`define ARCS_IDX_NEG_PM        12'h348
`define ARCS_IDX_NEG_VL        12'h349
`define ARCS_IDX_NEG_PL        12'h34a
`define ARCS_IDX_STAT_PCT      12'h380
`define ARCS_IDX_STAT_FREQ     12'h381

// Storage slots: 0..5 negative points, 6..11 positive points, then the settings.
`define ARCS_SLOT_NEG_VH       5'd0
`define ARCS_SLOT_NEG_PH       5'd1
`define ARCS_SLOT_NEG_VM       5'd2
`define ARCS_SLOT_NEG_PM       5'd3
`define ARCS_SLOT_NEG_VL       5'd4
`define ARCS_SLOT_NEG_PL       5'd5
`define ARCS_SLOT_POS_VL       5'd6
`define ARCS_SLOT_POS_PL       5'd7
`define ARCS_SLOT_POS_VM       5'd8
`define ARCS_SLOT_POS_PM       5'd9
`define ARCS_SLOT_POS_VH       5'd10
`define ARCS_SLOT_POS_PH       5'd11
`define ARCS_SLOT_CURVE        5'd12
`define ARCS_SLOT_TYPE         5'd13
`define ARCS_SLOT_BIAS         5'd14
`define ARCS_SLOT_MODE         5'd15
`define ARCS_SLOT_REVERSE      5'd16
`define ARCS_SLOT_GAIN         5'd17
`define ARCS_SLOT_FMAX         5'd18
`define ARCS_SLOTS             19

// Reset values (volts in 0.01 V, percent in 0.01 %, bias and gain in 0.1 %, Hz in 0.01 Hz).
`define ARCS_RST_ZERO          16'h0000
`define ARCS_RST_NEG_VM        16'hfe0c
`define ARCS_RST_NEG_VL        16'hfc18
`define ARCS_RST_NEG_PM        16'hec78
`define ARCS_RST_NEG_PL        16'hd8f0
`define ARCS_RST_POS_VM        16'h01f4
`define ARCS_RST_POS_VH        16'h03e8
`define ARCS_RST_POS_PM        16'h1388
`define ARCS_RST_POS_PH        16'h2710
`define ARCS_RST_GAIN          16'h03e8
`define ARCS_RST_FMAX          16'h1770

// Codes and scale factors.
`define ARCS_TYPE_BIPOLAR      16'h0002
`define ARCS_CURVE_FIRST       16'h0001
`define ARCS_CURVE_ALL         16'h0003
`define ARCS_PCT_FULL          16'h2710
`define ARCS_GAIN_UNITY        36'h0000003e8
`define ARCS_VOLT_TO_PCT       21'h00000a
`define ARCS_DIV_STEPS         6'd34

`endif

//--- hw/arcs_pkg.sv
// Types shared by the analog reference curve scaler.
package arcs_pkg;

    typedef enum logic [1:0] {
        ArcsIdle,
        ArcsDivide,
        ArcsDone
    } arcs_state_e;

    typedef logic signed [15:0] arcs_val_t;

    typedef struct packed {
        logic direct;
        logic cutoff;
        arcs_val_t xa;
        arcs_val_t xb;
        arcs_val_t pa;
        arcs_val_t pb;
        arcs_val_t val;
    } arcs_seg_s;

endpackage : arcs_pkg

//--- hw/arcs_scaler.sv
// Analog reference curve scaler with its APB register file.
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "arcs_defs.svh"

module arcs_scaler (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Digitised first analog input, 0.01 V per step
    input wire logic signed [15:0] firstAnalogInput,
    input wire logic sampleValid,
    // Speed reference
    output logic signed [16:0] freqCommand,
    output logic reverseDir,
    output logic refValid
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [5:0] slotOf(input logic [11:0] idx);
        logic [5:0] s;
        s = 6'h3f;
        if (idx >= `ARCS_IDX_POS_FIRST && idx <= `ARCS_IDX_NEG_LAST) begin
            s = (idx >= `ARCS_IDX_NEG_FIRST) ? 6'(idx - `ARCS_IDX_NEG_FIRST)
                                             : 6'(idx - `ARCS_IDX_POS_FIRST + 12'd6);
        end
        case (idx)
            `ARCS_IDX_CURVE_SELECT: s = {1'b0, `ARCS_SLOT_CURVE};
            `ARCS_IDX_TYPE_SELECT: s = {1'b0, `ARCS_SLOT_TYPE};
            `ARCS_IDX_FIRST_BIAS: s = {1'b0, `ARCS_SLOT_BIAS};
            `ARCS_IDX_BIAS_MODE: s = {1'b0, `ARCS_SLOT_MODE};
            `ARCS_IDX_REVERSE: s = {1'b0, `ARCS_SLOT_REVERSE};
            `ARCS_IDX_FIRST_GAIN: s = {1'b0, `ARCS_SLOT_GAIN};
            `ARCS_IDX_MAX_FREQ: s = {1'b0, `ARCS_SLOT_FMAX};
            default: s = s;
        endcase
        return s;
    endfunction : slotOf

    function automatic logic [15:0] resetOf(input int slot);
        logic [15:0] r;
        r = `ARCS_RST_ZERO;
        case (slot)
            `ARCS_SLOT_NEG_VM: r = `ARCS_RST_NEG_VM;
            `ARCS_SLOT_NEG_VL: r = `ARCS_RST_NEG_VL;
            `ARCS_SLOT_NEG_PM: r = `ARCS_RST_NEG_PM;
            `ARCS_SLOT_NEG_PL: r = `ARCS_RST_NEG_PL;
            `ARCS_SLOT_POS_VM: r = `ARCS_RST_POS_VM;
            `ARCS_SLOT_POS_VH: r = `ARCS_RST_POS_VH;
            `ARCS_SLOT_POS_PM: r = `ARCS_RST_POS_PM;
            `ARCS_SLOT_POS_PH: r = `ARCS_RST_POS_PH;
            `ARCS_SLOT_GAIN: r = `ARCS_RST_GAIN;
            `ARCS_SLOT_FMAX: r = `ARCS_RST_FMAX;
            default: r = `ARCS_RST_ZERO;
        endcase
        return r;
    endfunction : resetOf

    // Picks the segment of a three-point curve. The cutoff test is strict or
    // inclusive so that the default negative curve still reaches full reverse.
    function automatic arcs_pkg::arcs_seg_s segPick(
        input arcs_pkg::arcs_val_t x,
        input arcs_pkg::arcs_val_t v0,
        input arcs_pkg::arcs_val_t v1,
        input arcs_pkg::arcs_val_t v2,
        input arcs_pkg::arcs_val_t p0,
        input arcs_pkg::arcs_val_t p1,
        input arcs_pkg::arcs_val_t p2,
        input logic cutIncl
    );
        arcs_pkg::arcs_seg_s g;
        g = '0;
        if (cutIncl ? (x <= v0) : (x < v0)) begin
            g.direct = 1'b1;
            g.cutoff = 1'b1;
        end else if (x <= v1) begin
            g.xa = v0;
            g.xb = v1;
            g.pa = p0;
            g.pb = p1;
        end else if (x <= v2) begin
            g.xa = v1;
            g.xb = v2;
            g.pa = p1;
            g.pb = p2;
        end else begin
            g.direct = 1'b1;
            g.val = p2;
        end
        return g;
    endfunction : segPick

    function automatic arcs_pkg::arcs_val_t satPct(input logic signed [35:0] v);
        logic signed [35:0] full;
        full = 36'($signed(`ARCS_PCT_FULL));
        if (v > full) begin
            return `ARCS_PCT_FULL;
        end else if (v < -full) begin
            return -$signed(`ARCS_PCT_FULL);
        end
        return v[15:0];
    endfunction : satPct

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [15:0] cfg_q [`ARCS_SLOTS];
    logic [31:0] prdata_q;
    logic wrEver_q;
    arcs_pkg::arcs_val_t resultPct_q;
    logic signed [16:0] freqCmd_q;

    wire logic [11:0] regIdx = paddr[13:2];
    wire logic [5:0] regSlot = slotOf(regIdx);
    wire logic isStatus = (regIdx == `ARCS_IDX_STAT_PCT) || (regIdx == `ARCS_IDX_STAT_FREQ);
    wire logic isCfg = (regSlot < 6'(`ARCS_SLOTS));
    wire logic setupPhase = psel && !penable;
    wire logic wrEn = psel && penable && pwrite && isCfg;
    wire logic [31:0] rdValue = isCfg ? {16'h0000, cfg_q[regSlot[4:0]]}
                              : (regIdx == `ARCS_IDX_STAT_PCT) ? {16'h0000, resultPct_q}
                              : (regIdx == `ARCS_IDX_STAT_FREQ) ? {15'h0000, freqCmd_q}
                              : 32'h00000000;

    assign pready = penable;
    assign pslverr = psel && penable && !(isCfg || (isStatus && !pwrite));
    assign prdata = prdata_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `ARCS_SLOTS; i++) begin
                cfg_q[i] <= resetOf(i);
            end
            prdata_q <= 32'h00000000;
            wrEver_q <= 1'b0;
        end else begin
            if (wrEn) begin
                cfg_q[regSlot[4:0]] <= pwdata[15:0];
                wrEver_q <= 1'b1;
            end
            if (setupPhase && !pwrite) begin
                prdata_q <= rdValue;
            end
        end
    end

    // ------------------------------------------------------------
    // Segment selection
    // ------------------------------------------------------------
    wire logic [15:0] curveSel = cfg_q[`ARCS_SLOT_CURVE];
    wire logic curveOn = (curveSel == `ARCS_CURVE_FIRST) || (curveSel == `ARCS_CURVE_ALL);
    wire logic bipolar = (cfg_q[`ARCS_SLOT_TYPE] == `ARCS_TYPE_BIPOLAR);
    wire logic useNeg = curveOn && bipolar && firstAnalogInput[15];
    wire arcs_pkg::arcs_val_t xEff = (!bipolar && firstAnalogInput[15]) ? 16'h0000
                                   : firstAnalogInput;
    wire arcs_pkg::arcs_seg_s negSeg = segPick(xEff,
        cfg_q[`ARCS_SLOT_NEG_VL], cfg_q[`ARCS_SLOT_NEG_VM], cfg_q[`ARCS_SLOT_NEG_VH],
        cfg_q[`ARCS_SLOT_NEG_PL], cfg_q[`ARCS_SLOT_NEG_PM], cfg_q[`ARCS_SLOT_NEG_PH], 1'b0);
    wire arcs_pkg::arcs_seg_s posSeg = segPick(xEff,
        cfg_q[`ARCS_SLOT_POS_VL], cfg_q[`ARCS_SLOT_POS_VM], cfg_q[`ARCS_SLOT_POS_VH],
        cfg_q[`ARCS_SLOT_POS_PL], cfg_q[`ARCS_SLOT_POS_PM], cfg_q[`ARCS_SLOT_POS_PH], 1'b1);
    wire arcs_pkg::arcs_seg_s seg = useNeg ? negSeg : posSeg;

    // A span of zero or less means the points are misordered; hold the start percent.
    wire logic signed [16:0] span = 17'(seg.xb) - 17'(seg.xa);
    wire logic signed [16:0] dx = 17'(xEff) - 17'(seg.xa);
    wire logic signed [16:0] dp = 17'(seg.pb) - 17'(seg.pa);
    wire logic [16:0] dpMag = dp[16] ? 17'(-dp) : dp;
    wire logic [33:0] numer = 34'(dx[15:0]) * 34'(dpMag);
    wire logic badSpan = !seg.direct && (span <= 17'sh00000);

    // ------------------------------------------------------------
    // Bias and gain path
    // ------------------------------------------------------------
    wire logic signed [20:0] basePct = 21'(xEff) * $signed(`ARCS_VOLT_TO_PCT);
    wire logic signed [20:0] biasPct = 21'($signed(cfg_q[`ARCS_SLOT_BIAS]))
                                     * $signed(`ARCS_VOLT_TO_PCT);
    wire logic biasOn = (cfg_q[`ARCS_SLOT_MODE] != 16'h0000);
    wire logic signed [20:0] biased = biasOn ? (basePct + biasPct) : basePct;
    wire logic signed [35:0] gained = 36'(biased) * $signed({20'h00000, cfg_q[`ARCS_SLOT_GAIN]});
    wire logic signed [35:0] scaled = gained / $signed(`ARCS_GAIN_UNITY);
    wire logic noReverse = (cfg_q[`ARCS_SLOT_REVERSE] == 16'h0000);
    wire arcs_pkg::arcs_val_t normalPct = (noReverse && scaled[35]) ? 16'h0000
                                        : satPct(scaled);

    // ------------------------------------------------------------
    // Sequencer and divider
    // ------------------------------------------------------------
    arcs_pkg::arcs_state_e state_q;
    logic [33:0] quot_q;
    logic [17:0] rem_q;
    logic [16:0] den_q;
    logic [5:0] cnt_q;
    logic negSlope_q;
    logic direct_q;
    logic cutoff_q;
    logic normal_q;
    arcs_pkg::arcs_val_t base_q;
    logic [15:0] fmaxLat_q;
    logic refValid_q;
    logic reverse_q;

    wire logic start = (state_q == arcs_pkg::ArcsIdle) && sampleValid;
    wire logic [17:0] remShift = {rem_q[16:0], quot_q[33]};
    wire logic remFits = (remShift >= {1'b0, den_q});
    wire logic signed [35:0] interp = negSlope_q ? (36'(base_q) - 36'(quot_q))
                                                 : (36'(base_q) + 36'(quot_q));
    // Direct results pass the clamp as well, since breakpoint percents are stored unclamped.
    wire arcs_pkg::arcs_val_t finalPct = satPct(direct_q ? 36'(base_q) : interp);
    wire logic signed [32:0] freqProd = 33'(finalPct) * $signed({17'h00000, fmaxLat_q});
    wire logic signed [32:0] freqFull = freqProd / $signed({17'h00000, `ARCS_PCT_FULL});

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= arcs_pkg::ArcsIdle;
            quot_q <= 34'h000000000;
            rem_q <= 18'h00000;
            den_q <= 17'h00000;
            cnt_q <= 6'h00;
            negSlope_q <= 1'b0;
            direct_q <= 1'b0;
            cutoff_q <= 1'b0;
            normal_q <= 1'b0;
            base_q <= 16'h0000;
            fmaxLat_q <= 16'h0000;
        end else begin
            case (state_q)
                arcs_pkg::ArcsIdle: begin
                    if (sampleValid) begin
                        fmaxLat_q <= cfg_q[`ARCS_SLOT_FMAX];
                        normal_q <= !curveOn;
                        cutoff_q <= curveOn && seg.cutoff;
                        direct_q <= !curveOn || seg.direct || badSpan;
                        base_q <= !curveOn ? normalPct : (seg.direct ? seg.val : seg.pa);
                        quot_q <= numer;
                        rem_q <= 18'h00000;
                        den_q <= span;
                        negSlope_q <= dp[16];
                        cnt_q <= 6'h00;
                        state_q <= (!curveOn || seg.direct || badSpan) ? arcs_pkg::ArcsDone
                                                                      : arcs_pkg::ArcsDivide;
                    end
                end
                arcs_pkg::ArcsDivide: begin
                    rem_q <= remFits ? 18'(remShift - {1'b0, den_q}) : remShift;
                    quot_q <= {quot_q[32:0], remFits};
                    cnt_q <= cnt_q + 6'h01;
                    if (cnt_q == `ARCS_DIV_STEPS - 6'h01) begin
                        state_q <= arcs_pkg::ArcsDone;
                    end
                end
                arcs_pkg::ArcsDone: begin
                    state_q <= arcs_pkg::ArcsIdle;
                end
                default: begin
                    state_q <= arcs_pkg::ArcsIdle;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resultPct_q <= 16'h0000;
            freqCmd_q <= 17'h00000;
            refValid_q <= 1'b0;
            reverse_q <= 1'b0;
        end else begin
            refValid_q <= (state_q == arcs_pkg::ArcsDone);
            if (state_q == arcs_pkg::ArcsDone) begin
                resultPct_q <= finalPct;
                freqCmd_q <= freqFull[16:0];
                reverse_q <= finalPct[15];
            end
        end
    end

    assign freqCommand = freqCmd_q;
    assign reverseDir = reverse_q;
    assign refValid = refValid_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic signed [15:0] xLat_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xLat_q <= 16'h0000;
        end else if (start) begin
            xLat_q <= xEff;
        end
    end

    neg_needs_bipolar_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start && !bipolar && firstAnalogInput[15]
        |-> xEff == 16'sh0000 && seg == posSeg)
        else $error("negative points used without bipolar input type");

    neg_volt_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wrEver_q |-> cfg_q[`ARCS_SLOT_NEG_VH] == `ARCS_RST_ZERO
            && cfg_q[`ARCS_SLOT_NEG_VM] == `ARCS_RST_NEG_VM
            && cfg_q[`ARCS_SLOT_NEG_VL] == `ARCS_RST_NEG_VL)
        else $error("negative voltage point default wrong");

    neg_prop_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !wrEver_q |-> cfg_q[`ARCS_SLOT_NEG_PH] == `ARCS_RST_ZERO
            && cfg_q[`ARCS_SLOT_NEG_PM] == `ARCS_RST_NEG_PM
            && cfg_q[`ARCS_SLOT_NEG_PL] == `ARCS_RST_NEG_PL)
        else $error("negative percent point default wrong");

    reverse_flag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        refValid_q |-> reverse_q == resultPct_q[15] && (freqCmd_q <= 17'sh00000) == reverse_q
            || resultPct_q == 16'sh0000 || freqCmd_q == 17'sh00000)
        else $error("direction does not follow result sign");

    cutoff_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start && curveOn && seg.cutoff |-> ##2 refValid_q && resultPct_q == 16'sh0000)
        else $error("cutoff did not give zero output");

    curve_mode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        start && curveOn && !seg.direct && !badSpan |=> state_q == arcs_pkg::ArcsDivide
            ##[34:34] state_q == arcs_pkg::ArcsDone)
        else $error("three-point division did not take its steps");

    default_map_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        refValid_q && normal_q && $past(cfg_q[`ARCS_SLOT_GAIN], 2) == `ARCS_RST_GAIN
            && $past(!biasOn, 2) && $past(noReverse, 2)
        |-> resultPct_q == (xLat_q[15] ? 16'sh0000 : 16'(xLat_q * 16'sh000a)))
        else $error("default bias and gain mapping wrong");

    // The bound is the limit latched for this result; no newer take can replace it before the check.
    freq_bound_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        refValid_q |-> freqCmd_q <= $signed({1'b0, $past(fmaxLat_q)})
            && freqCmd_q >= -$signed({1'b0, $past(fmaxLat_q)}))
        else $error("frequency command above maximum");

    pct_saturate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        resultPct_q <= $signed(`ARCS_PCT_FULL) && resultPct_q >= -$signed(`ARCS_PCT_FULL))
        else $error("result percent outside full scale");

endmodule : arcs_scaler

//--- test/arcs_scaler_tb.sv
// Self-checking testbench of the analog reference curve scaler.
`timescale 1ns/100ps
`include "arcs_defs.svh"

module arcs_scaler_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam int CYCLE_LIMIT = 20000;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic signed [15:0] firstAnalogInput = 16'h0000;
    logic sampleValid = 1'b0;
    logic signed [16:0] freqCommand;
    logic reverseDir;
    logic refValid;
    int errors = 0;
    int checks = 0;
    int cycles = 0;

    arcs_scaler dut_u (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .firstAnalogInput(firstAnalogInput),
        .sampleValid(sampleValid),
        .freqCommand(freqCommand),
        .reverseDir(reverseDir),
        .refValid(refValid)
    );

    initial begin
        forever #25 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("Checks %0d, errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : stop_test

    always @(posedge core_clk) begin
        cycles++;
        if (cycles >= CYCLE_LIMIT) begin
            errors++;
            $display("Error at %0t: run timed out", $time);
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wdata;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        chk({31'h0, pready}, 32'h00000001, "apb answer");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic wr(input logic [11:0] idx, input logic [15:0] val);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, {16'h0000, val}, d, e);
        chk({31'h0, e}, 32'h00000000, "write error flag");
    endtask : wr

    task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input logic expErr,
                      input string what);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, 32'h00000000, d, e);
        chk(d, exp, what);
        chk({31'h0, e}, {31'h0, expErr}, what);
    endtask : rd

    // Presents one sample and waits a bounded time for its result pulse.
    task automatic conv(input logic [15:0] x, input logic [16:0] expF, input string what);
        int n;
        n = 0;
        firstAnalogInput <= x;
        sampleValid <= 1'b1;
        @(posedge core_clk);
        sampleValid <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
        end while (refValid !== 1'b1 && n < 60);
        chk({31'h0, refValid}, 32'h00000001, what);
        chk({15'h0, freqCommand}, {15'h0, expF}, what);
        chk({31'h0, reverseDir}, {31'h0, expF[16]}, what);
        @(posedge core_clk);
    endtask : conv

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [15:0] dflt [6];
        dflt = '{16'h0000, 16'h0000, 16'hfe0c, 16'hec78, 16'hfc18, 16'hd8f0};
        chk({15'h0, freqCommand}, 32'h00000000, "output after reset");
        for (int i = 0; i < 6; i++) begin
            rd(`ARCS_IDX_NEG_FIRST + 12'(i), 32'(dflt[i]), 1'b0, "default");
        end
        wr(`ARCS_IDX_NEG_VM, 16'hfc19);
        rd(`ARCS_IDX_NEG_VM, 32'h0000fc19, 1'b0, "signed volt");
        wr(`ARCS_IDX_NEG_VM, 16'hfe0c);
        rd(12'h200, 32'h00000000, 1'b1, "unmapped index");
    endtask : t_regs

    task automatic t_bias_gain();
        wr(`ARCS_IDX_REVERSE, 16'h0000);
        wr(`ARCS_IDX_TYPE_SELECT, 16'h0000);
        conv(16'h01f4, 17'h00bb8, "half scale");
        conv(16'h03e8, 17'h01770, "full scale");
        conv(16'hfe0c, 17'h00000, "negative unipolar");
        wr(`ARCS_IDX_FIRST_BIAS, 16'h0064);
        wr(`ARCS_IDX_BIAS_MODE, 16'h0001);
        conv(16'h01f4, 17'h00e10, "bias added");
        wr(`ARCS_IDX_BIAS_MODE, 16'h0000);
        wr(`ARCS_IDX_FIRST_GAIN, 16'h07d0);
        conv(16'h03e8, 17'h01770, "saturated");
        wr(`ARCS_IDX_FIRST_GAIN, 16'h01f4);
        conv(16'h03e8, 17'h00bb8, "half gain");
        wr(`ARCS_IDX_FIRST_GAIN, 16'h03e8);
        wr(`ARCS_IDX_MAX_FREQ, 16'h1b58);
        conv(16'h03e8, 17'h01b58, "raised fmax");
        wr(`ARCS_IDX_MAX_FREQ, 16'h1770);
    endtask : t_bias_gain

    task automatic t_curve();
        wr(`ARCS_IDX_CURVE_SELECT, 16'h0001);
        conv(16'hfe0c, 17'h00000, "negative unipolar curve");
        wr(`ARCS_IDX_TYPE_SELECT, 16'h0002);
        conv(16'hfc18, 17'h1e890, "full reverse");
        conv(16'hff06, 17'h1fa24, "negative span");
        rd(`ARCS_IDX_STAT_PCT, 32'h0000f63c, 1'b0, "result percent");
        conv(16'h02ee, 17'h01194, "positive span");
        wr(`ARCS_IDX_NEG_VM, 16'hffce);
        wr(`ARCS_IDX_NEG_PM, 16'h01f4);
        wr(`ARCS_IDX_NEG_VL, 16'hff9c);
        wr(`ARCS_IDX_NEG_PL, 16'h03e8);
        conv(16'hff9b, 17'h00000, "beyond lowest");
        conv(16'hff9c, 17'h00258, "step at lowest");
        conv(16'hff92, 17'h00000, "swing out");
        conv(16'hff9c, 17'h00258, "swing back");
        conv(16'hffce, 17'h0012c, "curve one");
        wr(`ARCS_IDX_CURVE_SELECT, 16'h0002);
        conv(16'hffce, 17'h00000, "curve two");
        wr(`ARCS_IDX_CURVE_SELECT, 16'h0003);
        conv(16'hffce, 17'h0012c, "curve three");
    endtask : t_curve

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_bias_gain();
        t_curve();
        stop_test();
    end
endmodule : arcs_scaler_tb
